//--- hdl/spmsfr_pkg.sv
// constants, field layouts and carrier types of the speech mcu sfr bank
package spmsfr_pkg;

	typedef logic [3:0] spmsfr_nib_t;
	typedef logic [4:0] spmsfr_addr_t;

	// nibble addresses in the common page
	localparam spmsfr_addr_t A_PWM_CONTROL   = 5'h09;
	localparam spmsfr_addr_t A_SAMPLE_LOW    = 5'h0A;
	localparam spmsfr_addr_t A_SAMPLE_HIGH   = 5'h0B;
	localparam spmsfr_addr_t A_PORT_D_DIR    = 5'h0C;
	localparam spmsfr_addr_t A_PORT_D_VALUE  = 5'h0D;
	localparam spmsfr_addr_t A_PORT_E_VALUE  = 5'h0E;
	localparam spmsfr_addr_t A_SCRATCH_TWO   = 5'h0F;
	localparam spmsfr_addr_t A_TRIM_GAIN     = 5'h10;
	localparam spmsfr_addr_t A_FORMAT_GAIN   = 5'h11;
	localparam spmsfr_addr_t A_SPK_WAKE      = 5'h12;
	localparam spmsfr_addr_t A_LOW_V_CTRL    = 5'h13;
	localparam spmsfr_addr_t A_LOW_V_LEVEL   = 5'h14;
	localparam spmsfr_addr_t A_ROM_BYTE_LO   = 5'h1C;
	localparam spmsfr_addr_t A_ROM_BYTE_HI   = 5'h1D;

	// rom pointer nibbles, least significant first
	localparam int           PTR_NIBS        = 5;
	localparam spmsfr_addr_t A_ROM_PTR [PTR_NIBS] = '{5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1E};

	// field positions
	localparam int B_AUDIO_OUT_ON   = 0;
	localparam int B_GLOBAL_IRQ_ON  = 1;
	localparam int B_LOW_DETECT_ON  = 0;
	localparam int B_LOW_FLAG       = 1;
	localparam int B_SPK_WAKE_ON    = 0;
	localparam int B_SPK_SENS_LO    = 1;
	localparam int B_SPK_SENS_HI    = 2;
	localparam int B_SPK_FLAG       = 3;
	localparam int B_TRIM_LO        = 0;
	localparam int B_TRIM_HI        = 1;
	localparam int B_GSEL_LO        = 2;
	localparam int B_GSEL_HI        = 3;
	localparam int B_INVERT_FMT     = 2;
	localparam int B_GAIN_ON        = 3;

	// reset values and neutral read value
	localparam spmsfr_nib_t NIB_ZERO = 4'h0;

	// sample resolutions
	localparam int SAMPLE_W = 12;
	typedef enum logic [1:0] {
		RES_8  = 2'b00,
		RES_10 = 2'b01,
		RES_12 = 2'b10
	} spmsfr_res_t;

	// watchdog span in system clocks
	localparam int WDT_SPAN_CYCLES = 256 * 256 * 16;
	localparam int WDT_W           = 21;

	// fixed configuration options
	typedef struct packed {
		logic port_e_bidir_option;
		logic freq_trim_option;
		logic amp_option;
		logic comparator_option;
		logic ten_bit_option;
		logic twelve_bit_option;
		logic watchdog_option;
	} spmsfr_opt_t;

	// one assembled sample, right aligned
	typedef struct packed {
		spmsfr_res_t          res;
		logic                 sample_sign;
		logic [SAMPLE_W-1:0]  value;
	} spmsfr_sample_t;

	// core nibble access
	typedef struct packed {
		logic         wr;
		logic         rd;
		spmsfr_addr_t addr;
		spmsfr_nib_t  wdata;
	} spmsfr_cpu_req_t;

endpackage : spmsfr_pkg

//--- hdl/spmsfr_bank.sv
// special function register bank, nibbles 09h to 1fh, of the speech mcu
// Behaviour
// - pwm control bit 0 switches audio output
// - pwm control bit 1 gates audio interrupts
// - low sample nibble placed per resolution
// - high sample nibble placed per resolution
// - top high nibble bit is sample sign
// - port d direction bit one means output
// - port d reads pins, writes drive outputs
// - port e direction follows bidirectional option
// - trim field shifts oscillator when option set
// - gain select valid with options and enable
// - gain enable switches record gain stage
// - format bit inverts sample except sign
// - hardware sets speaker wake flag, software clears
// - speaker wake allowed only when enabled
// - two bit speaker wake sensitivity select
// - read only low supply flag bit 1
// - low voltage control bit 0 enables detect
// - four bit low voltage threshold select
// - five nibbles form 20 bit rom address
// - rom low register reads byte bits 3..0
// - rom high register reads byte bits 7..4
// - write rom high clears enabled watchdog
// - extra bits used per ten/twelve option
// - watchdog overflow resets whole system
`timescale 1ns/100ps
module spmsfr_bank #(
	parameter int WDT_CYCLES = spmsfr_pkg::WDT_SPAN_CYCLES
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_n_i,
	input  wire spmsfr_pkg::spmsfr_cpu_req_t cpu_req_i,
	output logic [3:0]                      cpu_rdata_o,
	output logic                            cpu_rvalid_o,
	input  wire spmsfr_pkg::spmsfr_opt_t    option_i,
	input  wire logic [3:0]                 sample_extra_bits_i,
	output spmsfr_pkg::spmsfr_sample_t      sample_o,
	output logic                            sample_valid_o,
	input  wire logic                       sample_ready_i,
	output logic                            sample_room_o,
	output logic                            audio_out_on_o,
	output logic                            global_irq_on_o,
	input  wire logic                       audio_irq_req_i,
	output logic                            irq_accept_o,
	input  wire logic [3:0]                 port_d_pins_i,
	output logic [3:0]                      port_d_bits_o,
	output logic [3:0]                      port_d_oe_o,
	input  wire logic [3:0]                 port_e_pins_i,
	input  wire logic [3:0]                 port_e_dir_i,
	output logic [3:0]                      port_e_bits_o,
	output logic [3:0]                      port_e_oe_o,
	output logic [1:0]                      freq_trim_o,
	output logic                            freq_trim_active_o,
	output logic [1:0]                      record_gain_select_o,
	output logic                            record_gain_on_o,
	output logic                            record_gain_active_o,
	input  wire logic                       speaker_activity_i,
	output logic                            speaker_wake_o,
	output logic [1:0]                      speaker_wake_sensitivity_o,
	input  wire logic                       low_supply_sense_i,
	output logic                            low_supply_detect_on_o,
	output logic [3:0]                      low_supply_level_o,
	output logic [19:0]                     rom_addr_o,
	input  wire logic [7:0]                 rom_data_i,
	input  wire logic                       halt_wake_i,
	output logic                            wdt_reset_o
);
	import spmsfr_pkg::*;

	localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
	localparam logic [WDT_W-1:0] WDT_ONE  = WDT_W'(1);

	// write strobes, one per register
	wire wr_pwm    = cpu_req_i.wr && (cpu_req_i.addr == A_PWM_CONTROL);
	wire wr_low    = cpu_req_i.wr && (cpu_req_i.addr == A_SAMPLE_LOW);
	wire wr_high   = cpu_req_i.wr && (cpu_req_i.addr == A_SAMPLE_HIGH);
	wire wr_pd_dir = cpu_req_i.wr && (cpu_req_i.addr == A_PORT_D_DIR);
	wire wr_pd_val = cpu_req_i.wr && (cpu_req_i.addr == A_PORT_D_VALUE);
	wire wr_pe_val = cpu_req_i.wr && (cpu_req_i.addr == A_PORT_E_VALUE);
	wire wr_scr    = cpu_req_i.wr && (cpu_req_i.addr == A_SCRATCH_TWO);
	wire wr_trim   = cpu_req_i.wr && (cpu_req_i.addr == A_TRIM_GAIN);
	wire wr_fmt    = cpu_req_i.wr && (cpu_req_i.addr == A_FORMAT_GAIN);
	wire wr_spk    = cpu_req_i.wr && (cpu_req_i.addr == A_SPK_WAKE);
	wire wr_lvc    = cpu_req_i.wr && (cpu_req_i.addr == A_LOW_V_CTRL);
	wire wr_lvl    = cpu_req_i.wr && (cpu_req_i.addr == A_LOW_V_LEVEL);
	wire wr_romhi  = cpu_req_i.wr && (cpu_req_i.addr == A_ROM_BYTE_HI);

	// control registers
	logic        pwm_on_q, irq_on_q;
	spmsfr_nib_t sample_low_q;
	spmsfr_nib_t pd_dir_q, pd_val_q, pe_val_q, scratch_q;
	spmsfr_nib_t trim_gain_q, fmt_gain_q;
	logic        spk_flag_q, spk_on_q;
	logic [1:0]  spk_sens_q;
	logic        lv_on_q, lv_flag_q;
	spmsfr_nib_t lv_level_q;
	spmsfr_nib_t ptr_q [PTR_NIBS];

	// plain nibble registers; writes elsewhere are dropped
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) begin
			pwm_on_q     <= 1'b0;
			irq_on_q     <= 1'b0;
			sample_low_q <= NIB_ZERO;
			pd_dir_q     <= NIB_ZERO;
			pd_val_q     <= NIB_ZERO;
			pe_val_q     <= NIB_ZERO;
			scratch_q    <= NIB_ZERO;
			trim_gain_q  <= NIB_ZERO;
			fmt_gain_q   <= NIB_ZERO;
			spk_on_q     <= 1'b0;
			spk_sens_q   <= 2'h0;
			lv_on_q      <= 1'b0;
			lv_level_q   <= NIB_ZERO;
		end else begin
			if (wr_pwm) begin
				pwm_on_q <= cpu_req_i.wdata[B_AUDIO_OUT_ON];
				irq_on_q <= cpu_req_i.wdata[B_GLOBAL_IRQ_ON];
			end
			if (wr_low)    sample_low_q <= cpu_req_i.wdata;
			if (wr_pd_dir) pd_dir_q     <= cpu_req_i.wdata;
			if (wr_pd_val) pd_val_q     <= cpu_req_i.wdata;
			if (wr_pe_val) pe_val_q     <= cpu_req_i.wdata;
			if (wr_scr)    scratch_q    <= cpu_req_i.wdata;
			if (wr_trim)   trim_gain_q  <= cpu_req_i.wdata;
			if (wr_fmt)    fmt_gain_q   <= cpu_req_i.wdata;
			if (wr_spk) begin
				spk_on_q   <= cpu_req_i.wdata[B_SPK_WAKE_ON];
				spk_sens_q <= cpu_req_i.wdata[B_SPK_SENS_HI:B_SPK_SENS_LO];
			end
			if (wr_lvc)    lv_on_q      <= cpu_req_i.wdata[B_LOW_DETECT_ON];
			if (wr_lvl)    lv_level_q   <= cpu_req_i.wdata;
		end
	end

	// rom pointer nibbles, each at its own address
	genvar gi;
	generate
		for (gi = 0; gi < PTR_NIBS; gi++) begin : g_ptr
			wire wr_ptr = cpu_req_i.wr && (cpu_req_i.addr == A_ROM_PTR[gi]);
			always_ff @(posedge sys_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					ptr_q[gi] <= NIB_ZERO;
				else if (wr_ptr)
					ptr_q[gi] <= cpu_req_i.wdata;
			end
		end
	endgenerate

	// speaker wake flag: a wake in the clearing cycle still sets it
	wire spk_event = speaker_activity_i && spk_on_q;
	wire spk_keep  = wr_spk ? (cpu_req_i.wdata[B_SPK_FLAG] && spk_flag_q) : spk_flag_q;
	wire spk_flag_d = spk_event || spk_keep;

	// low supply flag only meaningful while detection runs
	wire lv_flag_d = low_supply_sense_i && lv_on_q;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) begin
			spk_flag_q <= 1'b0;
			lv_flag_q  <= 1'b0;
		end else begin
			spk_flag_q <= spk_flag_d;
			lv_flag_q  <= lv_flag_d;
		end
	end

	// sample assembly; the high nibble write completes a sample
	wire         use12  = option_i.twelve_bit_option;
	wire         use10  = option_i.ten_bit_option && !option_i.twelve_bit_option;
	wire [11:0]  raw12  = {cpu_req_i.wdata, sample_low_q, sample_extra_bits_i};
	wire [11:0]  raw10  = {2'b00, cpu_req_i.wdata, sample_low_q, sample_extra_bits_i[3:2]};
	wire [11:0]  raw8   = {4'h0, cpu_req_i.wdata, sample_low_q};
	wire [11:0]  raw    = use12 ? raw12 : (use10 ? raw10 : raw8);
	wire [11:0]  mag_m  = use12 ? 12'h7FF : (use10 ? 12'h1FF : 12'h07F);
	wire         invert = fmt_gain_q[B_INVERT_FMT];
	// sign bit stays, the rest flips in inverted format
	wire [11:0]  fmt_v  = invert ? (raw ^ mag_m) : raw;
	spmsfr_sample_t new_s;
	assign new_s.res         = use12 ? RES_12 : (use10 ? RES_10 : RES_8);
	assign new_s.sample_sign = cpu_req_i.wdata[3];
	assign new_s.value       = fmt_v;

	// two-entry skid buffer toward the pwm generator
	spmsfr_sample_t out_q, skid_q;
	logic           out_v_q, skid_v_q, room_q;
	wire push   = wr_high && room_q;
	wire pop    = out_v_q && sample_ready_i;
	wire take   = !out_v_q || pop;
	wire skid_v_d = take ? (skid_v_q && push) : (skid_v_q || push);

	// a full buffer refuses the sample; the core must watch room
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) begin
			out_q    <= '0;
			skid_q   <= '0;
			out_v_q  <= 1'b0;
			skid_v_q <= 1'b0;
			room_q   <= 1'b1;
		end else begin
			if (take) begin
				out_v_q <= skid_v_q || push;
				if (skid_v_q) out_q <= skid_q;
				else if (push) out_q <= new_s;
				if (skid_v_q && push) skid_q <= new_s;
			end else if (push) begin
				skid_q <= new_s;
			end
			skid_v_q <= skid_v_d;
			room_q   <= !skid_v_d;
		end
	end

	// watchdog: cleared by rom high write, wake or overflow itself
	logic [WDT_W-1:0] wdt_q;
	logic             wdt_rst_q;
	wire wdt_clear = wr_romhi || halt_wake_i;
	wire wdt_over  = option_i.watchdog_option && (wdt_q == WDT_LAST);
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) begin
			wdt_q     <= '0;
			wdt_rst_q <= 1'b0;
		end else begin
			if (!option_i.watchdog_option || wdt_clear || wdt_over)
				wdt_q <= '0;
			else
				wdt_q <= wdt_q + WDT_ONE;
			wdt_rst_q <= wdt_over;
		end
	end

	// read multiplexer; write-only and reserved read zero
	wire [19:0] ptr_cat = {ptr_q[4], ptr_q[3], ptr_q[2], ptr_q[1], ptr_q[0]};
	logic [3:0] rd_mux;
	always_comb
	begin
		unique case (cpu_req_i.addr)
			A_PWM_CONTROL:  rd_mux = {2'b00, irq_on_q, pwm_on_q};
			A_PORT_D_DIR:   rd_mux = pd_dir_q;
			A_PORT_D_VALUE: rd_mux = port_d_pins_i;
			A_PORT_E_VALUE: rd_mux = port_e_pins_i;
			A_SCRATCH_TWO:  rd_mux = scratch_q;
			A_TRIM_GAIN:    rd_mux = trim_gain_q;
			A_FORMAT_GAIN:  rd_mux = fmt_gain_q;
			A_SPK_WAKE:     rd_mux = {spk_flag_q, spk_sens_q, spk_on_q};
			A_LOW_V_CTRL:   rd_mux = {2'b00, lv_flag_q, lv_on_q};
			A_LOW_V_LEVEL:  rd_mux = lv_level_q;
			A_ROM_PTR[0]:   rd_mux = ptr_q[0];
			A_ROM_PTR[1]:   rd_mux = ptr_q[1];
			A_ROM_PTR[2]:   rd_mux = ptr_q[2];
			A_ROM_PTR[3]:   rd_mux = ptr_q[3];
			A_ROM_PTR[4]:   rd_mux = ptr_q[4];
			A_ROM_BYTE_LO:  rd_mux = rom_data_i[3:0];
			A_ROM_BYTE_HI:  rd_mux = rom_data_i[7:4];
			default:        rd_mux = NIB_ZERO;
		endcase
	end

	// registered outputs toward core and pins
	logic [3:0] rdata_q;
	logic       rvalid_q, irq_acc_q, wake_q;
	logic [3:0] pe_oe_q;
	logic       gain_act_q, trim_act_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) begin
			rdata_q    <= NIB_ZERO;
			rvalid_q   <= 1'b0;
			irq_acc_q  <= 1'b0;
			wake_q     <= 1'b0;
			pe_oe_q    <= NIB_ZERO;
			gain_act_q <= 1'b0;
			trim_act_q <= 1'b0;
		end else begin
			rvalid_q   <= cpu_req_i.rd;
			if (cpu_req_i.rd) rdata_q <= rd_mux;
			irq_acc_q  <= audio_irq_req_i && irq_on_q;
			wake_q     <= spk_event;
			pe_oe_q    <= option_i.port_e_bidir_option ? port_e_dir_i : NIB_ZERO;
			trim_act_q <= option_i.freq_trim_option;
			gain_act_q <= fmt_gain_q[B_GAIN_ON] && option_i.port_e_bidir_option
				&& option_i.amp_option && option_i.comparator_option;
		end
	end

	assign cpu_rdata_o                = rdata_q;
	assign cpu_rvalid_o               = rvalid_q;
	assign sample_o                   = out_q;
	assign sample_valid_o             = out_v_q;
	assign sample_room_o              = room_q;
	assign audio_out_on_o             = pwm_on_q;
	assign global_irq_on_o            = irq_on_q;
	assign irq_accept_o               = irq_acc_q;
	assign port_d_bits_o              = pd_val_q;
	assign port_d_oe_o                = pd_dir_q;
	assign port_e_bits_o              = pe_val_q;
	assign port_e_oe_o                = pe_oe_q;
	assign freq_trim_o                = trim_gain_q[B_TRIM_HI:B_TRIM_LO];
	assign freq_trim_active_o         = trim_act_q;
	assign record_gain_select_o       = trim_gain_q[B_GSEL_HI:B_GSEL_LO];
	assign record_gain_on_o           = fmt_gain_q[B_GAIN_ON];
	assign record_gain_active_o       = gain_act_q;
	assign speaker_wake_o             = wake_q;
	assign speaker_wake_sensitivity_o = spk_sens_q;
	assign low_supply_detect_on_o     = lv_on_q;
	assign low_supply_level_o         = lv_level_q;
	assign rom_addr_o                 = ptr_cat;
	assign wdt_reset_o                = wdt_rst_q;

endmodule : spmsfr_bank

//--- test/spmsfr_bank_sva.sv
// port-level assertion checker for the speech mcu sfr bank
`timescale 1ns/100ps
module spmsfr_bank_sva (
	input wire logic                        sys_clk_i,
	input wire logic                        rst_n_i,
	input wire spmsfr_pkg::spmsfr_cpu_req_t cpu_req_i,
	input wire logic [3:0]                  cpu_rdata_o,
	input wire logic                        cpu_rvalid_o,
	input wire logic                        audio_out_on_o,
	input wire logic                        global_irq_on_o,
	input wire logic                        audio_irq_req_i,
	input wire logic                        irq_accept_o,
	input wire logic [3:0]                  port_d_pins_i,
	input wire logic [3:0]                  port_d_oe_o,
	input wire logic                        speaker_activity_i,
	input wire logic                        speaker_wake_o,
	input wire logic                        low_supply_detect_on_o,
	input wire logic [19:0]                 rom_addr_o,
	input wire logic [7:0]                  rom_data_i,
	input wire logic                        wdt_reset_o
);
	import spmsfr_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// decoded accesses, so each property names its cause
	wire logic wr_pwm = cpu_req_i.wr && cpu_req_i.addr == A_PWM_CONTROL;
	wire logic wr_dir = cpu_req_i.wr && cpu_req_i.addr == A_PORT_D_DIR;
	wire logic wr_lv  = cpu_req_i.wr && cpu_req_i.addr == A_LOW_V_CTRL;
	wire logic rd_pd  = cpu_req_i.rd && cpu_req_i.addr == A_PORT_D_VALUE;
	wire logic rd_lo  = cpu_req_i.rd && cpu_req_i.addr == A_ROM_BYTE_LO;
	wire logic rd_hi  = cpu_req_i.rd && cpu_req_i.addr == A_ROM_BYTE_HI;
	property p_pwm;
		wr_pwm |=> audio_out_on_o == $past(cpu_req_i.wdata[0]) &&
			global_irq_on_o == $past(cpu_req_i.wdata[1]);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm control bits wrong");
	property p_irq;
		1 |=> irq_accept_o == $past(audio_irq_req_i && global_irq_on_o);
	endproperty
	a_irq: assert property (p_irq) else $error("irq accept wrong");
	property p_dir;
		wr_dir |=> port_d_oe_o == $past(cpu_req_i.wdata);
	endproperty
	a_dir: assert property (p_dir) else $error("port d enables wrong");
	property p_pins;
		rd_pd |=> cpu_rvalid_o && cpu_rdata_o == $past(port_d_pins_i);
	endproperty
	a_pins: assert property (p_pins) else $error("port d read wrong");
	property p_wake;
		speaker_wake_o |-> $past(speaker_activity_i);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without activity");
	property p_lvd;
		wr_lv |=> low_supply_detect_on_o == $past(cpu_req_i.wdata[0]);
	endproperty
	a_lvd: assert property (p_lvd) else $error("detect enable wrong");
	property p_ptr;
		!cpu_req_i.wr |=> $stable(rom_addr_o);
	endproperty
	a_ptr: assert property (p_ptr) else $error("rom pointer moved");
	property p_rlo;
		rd_lo |=> cpu_rvalid_o && cpu_rdata_o == $past(rom_data_i[3:0]);
	endproperty
	a_rlo: assert property (p_rlo) else $error("rom low read wrong");
	property p_rhi;
		rd_hi |=> cpu_rvalid_o && cpu_rdata_o == $past(rom_data_i[7:4]);
	endproperty
	a_rhi: assert property (p_rhi) else $error("rom high read wrong");
	property p_wdt;
		wdt_reset_o |=> (!wdt_reset_o)[*8];
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog pulse too long");
endmodule : spmsfr_bank_sva
bind spmsfr_bank spmsfr_bank_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o), .cpu_rvalid_o(cpu_rvalid_o),
	.audio_out_on_o(audio_out_on_o), .global_irq_on_o(global_irq_on_o),
	.audio_irq_req_i(audio_irq_req_i), .irq_accept_o(irq_accept_o),
	.port_d_pins_i(port_d_pins_i), .port_d_oe_o(port_d_oe_o),
	.speaker_activity_i(speaker_activity_i), .speaker_wake_o(speaker_wake_o),
	.low_supply_detect_on_o(low_supply_detect_on_o), .rom_addr_o(rom_addr_o),
	.rom_data_i(rom_data_i), .wdt_reset_o(wdt_reset_o));

//--- test/spmsfr_far_model.sv
// far side model: stalling sample consumer and data rom
`timescale 1ns/100ps
module spmsfr_far_model (
	input  wire logic        sys_clk_i,
	input  wire logic        stall_i,
	input  wire logic        sample_valid_i,
	input  wire logic [19:0] rom_addr_i,
	output logic             sample_ready_o,
	output logic [7:0]       rom_data_o,
	output logic [7:0]       pops_o
);
	// rom content mixes both address ends so a wrong nibble other than bits 15..12 shows
	assign rom_data_o = rom_addr_i[7:0] ^ {rom_addr_i[19:16], rom_addr_i[11:8]};
	assign sample_ready_o = !stall_i;
	logic [7:0] pop_cnt = 8'h00;
	assign pops_o = pop_cnt;
	// count samples taken, the only record the bench needs
	always @(posedge sys_clk_i)
		if (sample_valid_i && sample_ready_o)
			pop_cnt <= pop_cnt + 8'h01;
endmodule : spmsfr_far_model

//--- test/spmsfr_bank_tb.sv
// self-checking bench for the speech mcu sfr bank
`timescale 1ns/100ps
module spmsfr_bank_tb;
	import spmsfr_pkg::*;
	logic            sys_clk_i, rst_n_i, irq, act, sense, stall, srdy, sv, room, rv;
	logic            aon, gon, iacc, tact, gon2, gact, swk, lon, wdt;
	logic [3:0]      rdata, ext, pdp, pdb, pdo, pep, ped, peb, peo, lvl;
	logic [1:0]      trim, gsel, ssen;
	logic [19:0]     radr;
	logic [7:0]      rdat, pops;
	spmsfr_cpu_req_t req;
	spmsfr_opt_t     opt;
	spmsfr_sample_t  smp;
	int              n_mismatch, n_checks, cyc, wdt_n;
	spmsfr_addr_t    ra[6] = '{A_PORT_D_DIR, A_TRIM_GAIN, A_FORMAT_GAIN, A_SPK_WAKE,
		A_LOW_V_CTRL, A_LOW_V_LEVEL};
	spmsfr_bank #(.WDT_CYCLES(64)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.cpu_req_i(req), .cpu_rdata_o(rdata), .cpu_rvalid_o(rv), .option_i(opt),
		.sample_extra_bits_i(ext), .sample_o(smp), .sample_valid_o(sv),
		.sample_ready_i(srdy), .sample_room_o(room), .audio_out_on_o(aon),
		.global_irq_on_o(gon), .audio_irq_req_i(irq), .irq_accept_o(iacc),
		.port_d_pins_i(pdp), .port_d_bits_o(pdb), .port_d_oe_o(pdo), .port_e_pins_i(pep),
		.port_e_dir_i(ped), .port_e_bits_o(peb), .port_e_oe_o(peo), .freq_trim_o(trim),
		.freq_trim_active_o(tact), .record_gain_select_o(gsel), .record_gain_on_o(gon2),
		.record_gain_active_o(gact), .speaker_activity_i(act), .speaker_wake_o(swk),
		.speaker_wake_sensitivity_o(ssen), .low_supply_sense_i(sense),
		.low_supply_detect_on_o(lon), .low_supply_level_o(lvl), .rom_addr_o(radr),
		.rom_data_i(rdat), .halt_wake_i(1'b0), .wdt_reset_o(wdt));
	spmsfr_far_model far (.sys_clk_i(sys_clk_i), .stall_i(stall), .sample_valid_i(sv),
		.rom_addr_i(radr), .sample_ready_o(srdy), .rom_data_o(rdat), .pops_o(pops));
	initial
	begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	// hang guard and watchdog pulse counter
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (wdt === 1'b1)
			wdt_n++;
		if (cyc == 4000)
		begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic ck(input logic [19:0] g, input logic [19:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : ck
	task automatic cy(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : cy
	// a request stands one edge, then one idle edge
	task automatic wr(input spmsfr_addr_t a, input spmsfr_nib_t d);
		req = {1'b1, 1'b0, a, d};
		cy(1);
		req = '0;
		cy(1);
	endtask : wr
	task automatic rd(input spmsfr_addr_t a, input spmsfr_nib_t e);
		req = {1'b0, 1'b1, a, 4'h0};
		cy(1);
		req = '0;
		ck({rv, rdata}, {1'b1, e});
		cy(1);
	endtask : rd
	task automatic t_reset;
		foreach (ra[i]) rd(ra[i], 4'h0);
		ck({room, aon, pdo}, 6'h20);
	endtask : t_reset
	task automatic t_pwm;
		wr(A_PWM_CONTROL, 4'h3);
		irq = 1'b1;
		cy(2);
		ck({aon, gon, iacc}, 3'h7);
		wr(A_PWM_CONTROL, 4'h1);
		ck({aon, gon, iacc}, 3'h4);
		rd(A_PWM_CONTROL, 4'h1);
		irq = 1'b0;
		wr(A_PWM_CONTROL, 4'h0);
		ck(aon, 1'b0);
	endtask : t_pwm
	task automatic t_ports;
		wr(A_PORT_D_DIR, 4'h5);
		wr(A_PORT_D_VALUE, 4'hA);
		ck({pdo, pdb}, 8'h5A);
		pdp = 4'h6;
		rd(A_PORT_D_VALUE, 4'h6);
		ped = 4'h3;
		wr(A_PORT_E_VALUE, 4'hC);
		ck({peo, peb}, 8'h3C);
		pep = 4'h9;
		rd(A_PORT_E_VALUE, 4'h9);
		opt.port_e_bidir_option = 1'b0;
		cy(2);
		ck(peo, 4'h0);
	endtask : t_ports
	task automatic t_trim;
		opt = 7'h78;
		for (int i = 0; i < 4; i++)
		begin
			wr(A_TRIM_GAIN, {i[1:0], ~i[1:0]});
			ck({tact, gsel, trim}, {1'b1, i[1:0], ~i[1:0]});
		end
		wr(A_FORMAT_GAIN, 4'h8);
		cy(1);
		ck({gon2, gact}, 2'h3);
		wr(A_FORMAT_GAIN, 4'h0);
		cy(1);
		ck({gon2, gact}, 2'h0);
	endtask : t_trim
	// fill past capacity while stalled, then drain one at a time
	task automatic t_sample;
		opt = 7'h7E;
		ext = 4'h5;
		wr(A_SAMPLE_LOW, 4'h3);
		wr(A_SAMPLE_HIGH, 4'h9);
		wr(A_SAMPLE_LOW, 4'h6);
		wr(A_SAMPLE_HIGH, 4'h2);
		wr(A_SAMPLE_LOW, 4'hF);
		wr(A_SAMPLE_HIGH, 4'hF);
		ck({room, smp}, {1'b0, RES_12, 1'b1, 12'h935});
		stall = 1'b0;
		cy(1);
		ck(smp, {RES_12, 1'b0, 12'h265});
		cy(2);
		ck({sv, pops}, 9'h002);
		stall = 1'b1;
		opt.twelve_bit_option = 1'b0;
		wr(A_SAMPLE_LOW, 4'h3);
		wr(A_SAMPLE_HIGH, 4'h9);
		ck(smp, {RES_10, 1'b1, 12'h24D});
		opt.ten_bit_option = 1'b0;
		wr(A_FORMAT_GAIN, 4'h4);
		stall = 1'b0;
		cy(2);
		stall = 1'b1;
		wr(A_SAMPLE_HIGH, 4'h9);
		ck(smp, {RES_8, 1'b1, 12'h0EC});
		rd(A_SAMPLE_LOW, 4'h0);
	endtask : t_sample
	task automatic t_spk;
		for (int i = 0; i < 4; i++)
		begin
			wr(A_SPK_WAKE, {1'b0, i[1:0], 1'b0});
			ck(ssen, i[1:0]);
		end
		act = 1'b1;
		cy(2);
		ck(swk, 1'b0);
		rd(A_SPK_WAKE, 4'h6);
		wr(A_SPK_WAKE, 4'h7);
		ck(swk, 1'b1);
		rd(A_SPK_WAKE, 4'hF);
		wr(A_SPK_WAKE, 4'h7);
		rd(A_SPK_WAKE, 4'hF);
		act = 1'b0;
		wr(A_SPK_WAKE, 4'h7);
		rd(A_SPK_WAKE, 4'h7);
	endtask : t_spk
	task automatic t_low;
		wr(A_LOW_V_CTRL, 4'hF);
		rd(A_LOW_V_CTRL, 4'h1);
		sense = 1'b1;
		cy(2);
		rd(A_LOW_V_CTRL, 4'h3);
		wr(A_LOW_V_LEVEL, 4'hF);
		ck({lon, lvl}, 5'h1F);
		rd(A_LOW_V_LEVEL, 4'hF);
	endtask : t_low
	// pointer then reads; reserved writes must leave the pointer alone
	task automatic t_rom;
		for (int i = 0; i < PTR_NIBS; i++)
			wr(A_ROM_PTR[i], spmsfr_nib_t'(20'h5A3C1 >> (4 * i)));
		ck(radr, 20'h5A3C1);
		wr(5'h15, 4'hF);
		wr(A_ROM_BYTE_LO, 4'h0);
		rd(A_ROM_BYTE_LO, 4'h2);
		rd(A_ROM_BYTE_HI, 4'h9);
		rd(5'h15, 4'h0);
		rd(5'h1F, 4'h0);
		ck(radr, 20'h5A3C1);
	endtask : t_rom
	task automatic t_wdt;
		opt.watchdog_option = 1'b1;
		repeat (8)
		begin
			cy(8);
			wr(A_ROM_BYTE_HI, 4'h0);
		end
		ck(wdt_n, 0);
		cy(70);
		ck(wdt_n, 1);
	endtask : t_wdt
	initial
	begin
		{rst_n_i, irq, act, sense, ext, pdp, pep, ped, req} = '0;
		opt = 7'h40;
		stall = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		t_reset;
		t_pwm;
		t_ports;
		t_trim;
		t_sample;
		t_spk;
		t_low;
		t_rom;
		t_wdt;
		final_report;
	end
endmodule : spmsfr_bank_tb
